// ### iopbm_defs.svh
// Constants for the I/O port and external bus multiplexer.
// What this block does
// - Port 0 open drain; latch one floats.
// - External access drives Port 0 address/data actively.
// - Verify outputs code byte on Port 0.
// - Port 1 pulled-up bidirectional, readable when one.
// - Verify takes low address from Port 1.
// - Port 2 drives high address, fetch/wide move.
// - Short pointer move keeps Port 2 latch.
// - Programming takes high address, mode from Port 2.
// - Port 3 pulled-up; programming controls taken there.
// - Lock bits block external reads, verify, programming.
// - Idle stops core; other functions keep running.
// - Power-down stops everything, keeps RAM.
// - Verify bytes encrypted with 32-byte key array.
// - XNOR with key at address low five bits.
`ifndef IOPBM_DEFS_SVH
`define IOPBM_DEFS_SVH
`define IOPBM_LATCH_RESET 8'hff
`define IOPBM_KEY_BLANK   8'hff
`define IOPBM_KEY_ABITS   5
`define IOPBM_KEY_COUNT   32
`define IOPBM_HADDR_BITS  4
`define IOPBM_MODE_HI     7
`define IOPBM_MODE_LO     6
`define IOPBM_CTL_HI      7
`define IOPBM_CTL_LO      6
`endif

// ### iopbm_pkg.sv
// Types shared by the I/O port and external bus multiplexer.
package iopbm_pkg;
	typedef enum logic [2:0] {
		IOPBM_BUS_IDLE,
		IOPBM_BUS_FETCH,
		IOPBM_BUS_WIDE,
		IOPBM_BUS_SHORT
	} iopbm_bus_t;
	typedef enum logic [2:0] {
		IOPBM_PM_NONE,
		IOPBM_PM_CODE,
		IOPBM_PM_VERIFY,
		IOPBM_PM_KEY,
		IOPBM_PM_LOCK1,
		IOPBM_PM_LOCK2,
		IOPBM_PM_SIG
	} iopbm_pmode_t;
	typedef enum logic [1:0] {
		IOPBM_PWR_RUN,
		IOPBM_PWR_IDLE,
		IOPBM_PWR_DOWN
	} iopbm_pwr_t;
endpackage

// ### iopbm_sync.sv
// Two-stage synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module iopbm_sync #(
	parameter int W = 8
) (
	input  wire logic         ref_clk, // Clock.
	input  wire logic         rst_n,   // Asynchronous reset.
	input  wire logic         clkEn,   // Clock enable.
	input  wire logic [W-1:0] async,   // Pin levels.
	output logic      [W-1:0] synced   // Synchronised levels.
);
	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_synced;

	always_comb begin
		next_stage1 = clkEn ? async : stage1;
		next_synced = clkEn ? stage1 : synced;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			// Pins idle high on their pull-ups, so reset to ones.
			// A zero here would look like a falling program pulse.
			stage1 <= '1;
			synced <= '1;
		end else begin
			stage1 <= next_stage1;
			synced <= next_synced;
		end
	end
endmodule
`default_nettype wire

// ### iopbm_keys.sv
// Encryption key array with verification byte scrambling.
`timescale 1ns/1ps
`default_nettype none
`include "iopbm_defs.svh"
module iopbm_keys #(
	parameter int N = `IOPBM_KEY_COUNT
) (
	input  wire logic                        ref_clk,  // Clock.
	input  wire logic                        rst_n,    // Asynchronous reset.
	input  wire logic                        clkEn,    // Clock enable.
	input  wire logic                        keyWr,    // Program one key.
	input  wire logic [`IOPBM_KEY_ABITS-1:0] keyAddr,  // Key index.
	input  wire logic [7:0]                  keyData,  // Key value.
	input  wire logic [7:0]                  rawByte,  // Unscrambled code.
	output logic      [7:0]                  codeOut   // Scrambled code.
);
	logic [7:0] keys [N];
	logic [7:0] next_keys [N];

	// Programming can only clear bits, like the erased cells it models.
	always_comb begin
		for (int i = 0; i < N; i++) begin
			next_keys[i] = keys[i];
		end
		if (clkEn && keyWr) begin
			next_keys[keyAddr] = keys[keyAddr] & keyData;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				keys[i] <= `IOPBM_KEY_BLANK;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				keys[i] <= next_keys[i];
			end
		end
	end

	// A blank key is all ones, so an unprogrammed array passes code through.
	assign codeOut = ~(rawByte ^ keys[keyAddr]);
endmodule
`default_nettype wire

// ### iopbm_ports.sv
// Four I/O ports with external bus and EPROM programming multiplexing.
`timescale 1ns/1ps
`default_nettype none
`include "iopbm_defs.svh"
module iopbm_ports
	import iopbm_pkg::*;
(
	input  wire logic        ref_clk,      // Clock.
	input  wire logic        rst_n,        // Asynchronous reset.
	input  wire logic        clkEn,        // Clock enable.
	input  wire logic [3:0]  latchWr,      // Core write strobe per port.
	input  wire logic [7:0]  latchData,    // Core write data.
	input  wire iopbm_bus_t  busCycle,     // Current external bus access.
	input  wire logic        busAddrPhase, // High: address on Port 0.
	input  wire logic        busWrite,     // External write data phase.
	input  wire logic [15:0] busAddr,      // External address.
	input  wire logic [7:0]  busWrData,    // External write data.
	input  wire logic        progEntry,    // Programming mode strobe.
	input  wire logic        progPulse,    // Program pulse, active low.
	input  wire logic [7:0]  romData,      // Code byte at verify address.
	input  wire logic        extFetch,     // Core runs external code.
	input  wire logic        intRomRead,   // Core reads internal code.
	input  wire logic        idleReq,      // Idle request.
	input  wire logic        downReq,      // Power-down request.
	input  wire logic        wakeIrq,      // Enabled interrupt.
	input  wire logic [7:0]  p0In,         // Port 0 pins.
	input  wire logic [7:0]  p1In,         // Port 1 pins.
	input  wire logic [7:0]  p2In,         // Port 2 pins.
	input  wire logic [7:0]  p3In,         // Port 3 pins.
	output logic      [7:0]  p0Out,        // Port 0 drive level.
	output logic      [7:0]  p0Oe,         // Port 0 drive enable.
	output logic      [7:0]  p1Out,        // Port 1 level.
	output logic      [7:0]  p1Oe,         // Port 1 strong drive.
	output logic      [7:0]  p2Out,        // Port 2 level.
	output logic      [7:0]  p2Oe,         // Port 2 strong drive.
	output logic      [7:0]  p3Out,        // Port 3 level.
	output logic      [7:0]  p3Oe,         // Port 3 strong drive.
	output logic      [31:0] portRead,     // Synchronised pin values.
	output logic      [15:0] progAddr,     // Programming address.
	output iopbm_pmode_t     progMode,     // Decoded programming mode.
	output logic      [7:0]  progData,     // Byte to program.
	output logic             progWrite,    // Program write pulse.
	output logic             romBlocked,   // Internal read refused.
	output logic             coreRun,      // Core clock enable.
	output logic             periphRun,    // Peripheral clock enable.
	output logic      [1:0]  lockBits      // Lock state.
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0] p0s, p1s, p2s, p3s;
	logic       pulseS;

	iopbm_sync #(.W(32)) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.async   ({p3In, p2In, p1In, p0In}),
		.synced  ({p3s, p2s, p1s, p0s})
	);
	iopbm_sync #(.W(1)) u_syncp (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.async   (progPulse),
		.synced  (pulseS)
	);

	////////////////////////////////////////////////////////////////////////
	logic [7:0]   lat0, lat1, lat2, lat3;
	logic [7:0]   next_lat0, next_lat1, next_lat2, next_lat3;
	iopbm_pwr_t   pwr, next_pwr;
	iopbm_pmode_t pmode, next_pmode;
	logic [1:0]   lock, next_lock;
	logic         pulseD, next_pulseD;

	// Decodes the programming mode from the two Port 2 and Port 3 pins.
	function automatic iopbm_pmode_t decodeMode(input logic [1:0] m,
		input logic [1:0] c, input logic pgm);
		iopbm_pmode_t r;
		r = IOPBM_PM_NONE;
		unique case ({m, c})
			4'h3: r = pgm ? IOPBM_PM_NONE : IOPBM_PM_VERIFY;
			4'h0: r = pgm ? IOPBM_PM_NONE : IOPBM_PM_SIG;
			4'hb: r = IOPBM_PM_CODE;
			4'ha: r = IOPBM_PM_KEY;
			4'hf: r = IOPBM_PM_LOCK1;
			4'hc: r = IOPBM_PM_LOCK2;
			default: r = IOPBM_PM_NONE;
		endcase
		return r;
	endfunction

	logic       pgmAllowed, verifyOn, pulseFall;
	logic [7:0] encByte;

	always_comb begin
		next_lat0 = lat0;
		next_lat1 = lat1;
		next_lat2 = lat2;
		next_lat3 = lat3;
		next_pwr = pwr;
		next_pmode = pmode;
		next_lock = lock;
		next_pulseD = pulseD;
		if (clkEn) begin
			next_pulseD = pulseS;
			// The oscillator is stopped, so no latch may change.
			if (pwr != IOPBM_PWR_DOWN) begin
				if (latchWr[0]) next_lat0 = latchData;
				if (latchWr[1]) next_lat1 = latchData;
				if (latchWr[2]) next_lat2 = latchData;
				if (latchWr[3]) next_lat3 = latchData;
			end
			unique case (pwr)
				IOPBM_PWR_RUN: begin
					// Power-down wins when both are asked at once.
					if (downReq) next_pwr = IOPBM_PWR_DOWN;
					else if (idleReq) next_pwr = IOPBM_PWR_IDLE;
				end
				IOPBM_PWR_IDLE: begin
					if (wakeIrq) next_pwr = IOPBM_PWR_RUN;
				end
				IOPBM_PWR_DOWN: next_pwr = IOPBM_PWR_DOWN;
			endcase
			next_pmode = progEntry ? decodeMode(
				{p2s[`IOPBM_MODE_HI], p2s[`IOPBM_MODE_LO]},
				{p3s[`IOPBM_CTL_HI], p3s[`IOPBM_CTL_LO]},
				!pulseS) : IOPBM_PM_NONE;
			if (pulseFall && pgmAllowed) begin
				if (pmode == IOPBM_PM_LOCK1) next_lock[0] = 1'b1;
				if (pmode == IOPBM_PM_LOCK2) next_lock[1] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lat0 <= `IOPBM_LATCH_RESET;
			lat1 <= `IOPBM_LATCH_RESET;
			lat2 <= `IOPBM_LATCH_RESET;
			lat3 <= `IOPBM_LATCH_RESET;
			pwr <= IOPBM_PWR_RUN;
			pmode <= IOPBM_PM_NONE;
			lock <= 2'h0;
			pulseD <= 1'b1;
		end else begin
			lat0 <= next_lat0;
			lat1 <= next_lat1;
			lat2 <= next_lat2;
			lat3 <= next_lat3;
			pwr <= next_pwr;
			pmode <= next_pmode;
			lock <= next_lock;
			pulseD <= next_pulseD;
		end
	end

	assign pulseFall = pulseD && !pulseS;
	// Lock two stops all programming except lock one.
	assign pgmAllowed = !lock[1] || pmode == IOPBM_PM_LOCK1;
	// Both lock bits together forbid verification.
	assign verifyOn = pmode == IOPBM_PM_VERIFY && lock != 2'h3;

	iopbm_keys u_keys (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.keyWr   (pulseFall && pmode == IOPBM_PM_KEY && pgmAllowed),
		.keyAddr (p1s[`IOPBM_KEY_ABITS-1:0]),
		.keyData (p0s),
		.rawByte (romData),
		.codeOut (encByte)
	);

	////////////////////////////////////////////////////////////////////////
	logic [7:0] n0o, n0e, n2o, n2e;
	logic [15:0] next_pAddr;

	always_comb begin
		n0o = lat0;
		n0e = ~lat0;
		n2o = lat2;
		n2e = ~lat2;
		next_pAddr = {{(16 - `IOPBM_HADDR_BITS - 8){1'b0}},
			p2s[`IOPBM_HADDR_BITS-1:0], p1s};
		if (verifyOn) begin
			// Verify can only sink; the programmer pulls the ones up.
			n0o = encByte;
			n0e = ~encByte;
			n2e = 8'h00;
		end else if (pmode != IOPBM_PM_NONE) begin
			n0e = 8'h00;
			n2e = 8'h00;
		end else if (busCycle != IOPBM_BUS_IDLE) begin
			n0o = busAddrPhase ? busAddr[7:0] : busWrData;
			n0e = (busAddrPhase || busWrite) ? 8'hff : 8'h00;
			if (busCycle != IOPBM_BUS_SHORT) begin
				n2o = busAddr[15:8];
				n2e = 8'hff;
			end
		end else if (pwr == IOPBM_PWR_DOWN && extFetch) begin
			n0e = 8'h00;
		end else if (pwr == IOPBM_PWR_IDLE && extFetch) begin
			n0e = 8'h00;
			n2o = busAddr[15:8];
			n2e = 8'hff;
		end
	end

	logic [7:0]   next_p0Out, next_p0Oe, next_p1Out, next_p1Oe;
	logic [7:0]   next_p2Out, next_p2Oe, next_p3Out, next_p3Oe;
	logic [31:0]  next_portRead;
	logic [15:0]  next_progAddr;
	iopbm_pmode_t next_progMode;
	logic [7:0]   next_progData;
	logic         next_progWrite, next_romBlocked;
	logic         next_coreRun, next_periphRun;
	logic [1:0]   next_lockBits;

	// Every output holds its value while the clock enable is low.
	always_comb begin
		next_p0Out = p0Out;
		next_p0Oe = p0Oe;
		next_p1Out = p1Out;
		next_p1Oe = p1Oe;
		next_p2Out = p2Out;
		next_p2Oe = p2Oe;
		next_p3Out = p3Out;
		next_p3Oe = p3Oe;
		next_portRead = portRead;
		next_progAddr = progAddr;
		next_progMode = progMode;
		next_progData = progData;
		next_progWrite = progWrite;
		next_romBlocked = romBlocked;
		next_coreRun = coreRun;
		next_periphRun = periphRun;
		next_lockBits = lockBits;
		if (clkEn) begin
			next_p0Out = n0o;
			next_p0Oe = n0e;
			// Ones are left to the weak pull-ups so pins stay readable.
			next_p1Out = lat1;
			next_p1Oe = pmode != IOPBM_PM_NONE ? 8'h00
				: ~lat1;
			next_p2Out = n2o;
			next_p2Oe = n2e;
			next_p3Out = lat3;
			next_p3Oe = pmode != IOPBM_PM_NONE ? 8'h00
				: ~lat3;
			next_portRead = {p3s, p2s, p1s, p0s};
			next_progAddr = next_pAddr;
			next_progMode = pmode;
			next_progData = p0s;
			next_progWrite = pulseFall && pgmAllowed
				&& pmode == IOPBM_PM_CODE;
			next_romBlocked = lock != 2'h0 && extFetch
				&& intRomRead;
			next_coreRun = next_pwr == IOPBM_PWR_RUN;
			next_periphRun = next_pwr != IOPBM_PWR_DOWN;
			next_lockBits = lock;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			p0Out <= `IOPBM_LATCH_RESET;
			p0Oe <= 8'h00;
			p1Out <= `IOPBM_LATCH_RESET;
			p1Oe <= 8'h00;
			p2Out <= `IOPBM_LATCH_RESET;
			p2Oe <= 8'h00;
			p3Out <= `IOPBM_LATCH_RESET;
			p3Oe <= 8'h00;
			portRead <= '0;
			progAddr <= '0;
			progMode <= IOPBM_PM_NONE;
			progData <= '0;
			progWrite <= 1'b0;
			romBlocked <= 1'b0;
			coreRun <= 1'b1;
			periphRun <= 1'b1;
			lockBits <= 2'h0;
		end else begin
			p0Out <= next_p0Out;
			p0Oe <= next_p0Oe;
			p1Out <= next_p1Out;
			p1Oe <= next_p1Oe;
			p2Out <= next_p2Out;
			p2Oe <= next_p2Oe;
			p3Out <= next_p3Out;
			p3Oe <= next_p3Oe;
			portRead <= next_portRead;
			progAddr <= next_progAddr;
			progMode <= next_progMode;
			progData <= next_progData;
			progWrite <= next_progWrite;
			romBlocked <= next_romBlocked;
			coreRun <= next_coreRun;
			periphRun <= next_periphRun;
			lockBits <= next_lockBits;
		end
	end
endmodule
`default_nettype wire

// ### iopbm_ports_monitor.sv
// Concurrent checks on the I/O port multiplexer, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module iopbm_ports_monitor
	import iopbm_pkg::*;
(
	input wire logic         ref_clk,      // Clock.
	input wire logic         rst_n,        // Reset, low.
	input wire logic         clkEn,        // Clock enable.
	input wire logic [3:0]   latchWr,      // Latch strobes.
	input wire logic [7:0]   latchData,    // Latch data.
	input wire iopbm_bus_t   busCycle,     // Bus access.
	input wire logic         busAddrPhase, // Address phase.
	input wire logic [15:0]  busAddr,      // Bus address.
	input wire logic         progEntry,    // Programming.
	input wire logic         extFetch,     // External code.
	input wire logic         intRomRead,   // Internal read.
	input wire logic         idleReq,      // Idle request.
	input wire logic         downReq,      // Down request.
	input wire logic         wakeIrq,      // Wake event.
	input wire logic [7:0]   p0Out,        // Port 0 level.
	input wire logic [7:0]   p0Oe,         // Port 0 enable.
	input wire logic [7:0]   p1Oe,         // Port 1 enable.
	input wire logic [7:0]   p2Out,        // Port 2 level.
	input wire iopbm_pmode_t progMode,     // Decoded mode.
	input wire logic         romBlocked,   // Read refused.
	input wire logic         coreRun,      // Core enable.
	input wire logic         periphRun,    // Peripheral enable.
	input wire logic [1:0]   lockBits      // Lock state.
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	// Two quiet cycles are demanded so that either latency reading holds.
	chk_latch_drive: assert property (
		clkEn && latchWr[1] && periphRun && !progEntry ##1
		(clkEn && !latchWr[1] && !progEntry)[*2]
		|=> p1Oe == ~$past(latchData, 3))
		else $error("port 1 drive does not follow its latch");
	chk_port0_float: assert property (
		(busCycle == IOPBM_BUS_IDLE && !progEntry)[*6]
		|-> (p0Oe & p0Out) == 8'h00)
		else $error("port 0 drives a one outside bus cycles");
	chk_bus_addr: assert property (
		busCycle inside {IOPBM_BUS_FETCH, IOPBM_BUS_WIDE} && busAddrPhase
		&& clkEn && periphRun && !progEntry
		|=> {p2Out, p0Out} == $past(busAddr) && p0Oe == 8'hff)
		else $error("bus address not on ports 2 and 0");
	chk_verify_drain: assert property (
		(progEntry && progMode == IOPBM_PM_VERIFY)[*3]
		|-> p0Oe == ~p0Out || lockBits == 2'b11)
		else $error("verify byte not driven as open drain");
	chk_idle_entry: assert property (
		idleReq && !downReq && !wakeIrq && clkEn && periphRun
		|=> !coreRun && periphRun)
		else $error("idle did not stop only the core");
	chk_idle_wake: assert property (
		!coreRun && periphRun && wakeIrq && clkEn |=> coreRun)
		else $error("wake event did not restart the core");
	chk_down_entry: assert property (
		downReq && clkEn && periphRun |=> !coreRun && !periphRun)
		else $error("power-down did not stop everything");
	chk_down_stays: assert property (
		!periphRun |=> !periphRun)
		else $error("power-down left without reset");
	chk_lock_block: assert property (
		(lockBits != 2'b00 && extFetch && intRomRead)[*2] |-> romBlocked)
		else $error("locked internal read not refused");
endmodule
bind iopbm_ports iopbm_ports_monitor mon_u (.ref_clk, .rst_n, .clkEn,
	.latchWr, .latchData, .busCycle, .busAddrPhase, .busAddr, .progEntry,
	.extFetch, .intRomRead, .idleReq, .downReq, .wakeIrq, .p0Out, .p0Oe,
	.p1Oe, .p2Out, .progMode, .romBlocked, .coreRun, .periphRun, .lockBits);
`default_nettype wire

// ### iopbm_prog_model.sv
// Programmer and code store model standing on the port pins.
`timescale 1ns/1ps
`default_nettype none
module iopbm_prog_model (
	input  wire logic        ref_clk,  // Clock.
	input  wire logic [15:0] progAddr, // Decoded address.
	input  wire logic [7:0]  p0Out,    // Port 0 level.
	input  wire logic [7:0]  p0Oe,     // Port 0 enable.
	input  wire logic [7:0]  p1Out,    // Port 1 level.
	input  wire logic [7:0]  p1Oe,     // Port 1 enable.
	input  wire logic [7:0]  p2Out,    // Port 2 level.
	input  wire logic [7:0]  p2Oe,     // Port 2 enable.
	input  wire logic [7:0]  p3Out,    // Port 3 level.
	input  wire logic [7:0]  p3Oe,     // Port 3 enable.
	input  wire logic [7:0]  drv0,     // Far side on Port 0.
	input  wire logic [7:0]  drv1,     // Far side on Port 1.
	input  wire logic [7:0]  drv2,     // Far side on Port 2.
	input  wire logic [7:0]  drv3,     // Far side on Port 3.
	output logic      [7:0]  p0In,     // Port 0 wire.
	output logic      [7:0]  p1In,     // Port 1 wire.
	output logic      [7:0]  p2In,     // Port 2 wire.
	output logic      [7:0]  p3In,     // Port 3 wire.
	output logic      [7:0]  romData   // Stored code byte.
);
	// Every pin has a pull-up, so a low from either party wins.
	assign p0In = drv0 & (p0Out | ~p0Oe);
	assign p1In = drv1 & (p1Out | ~p1Oe);
	assign p2In = drv2 & (p2Out | ~p2Oe);
	assign p3In = drv3 & (p3Out | ~p3Oe);
	always_ff @(posedge ref_clk) begin
		romData <= progAddr[7:0] ^ {progAddr[11:8], progAddr[11:8]} ^ 8'h5a;
	end
endmodule
`default_nettype wire

// ### iopbm_ports_bench.sv
// Self-checking bench for the I/O port multiplexer.
`timescale 1ns/1ps
`default_nettype none
module iopbm_ports_bench;
	import iopbm_pkg::*;
	logic ref_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, progEntry = 1'b0;
	logic progPulse = 1'b1, busAddrPhase = 1'b0, busWrite = 1'b0;
	logic extFetch = 1'b0, intRomRead = 1'b0, idleReq = 1'b0;
	logic downReq = 1'b0, wakeIrq = 1'b0;
	logic [3:0] latchWr = 4'h0;
	logic [7:0] latchData = 8'h00, busWrData = 8'h00;
	logic [15:0] busAddr = 16'h0000;
	iopbm_bus_t busCycle = IOPBM_BUS_IDLE;
	logic [7:0] drv0 = 8'hff, drv1 = 8'hff, drv2 = 8'hff, drv3 = 8'hff;
	logic [7:0] romData, p0In, p1In, p2In, p3In, progData, d, k;
	logic [7:0] p0Out, p0Oe, p1Out, p1Oe, p2Out, p2Oe, p3Out, p3Oe;
	logic [31:0] portRead, allOe;
	logic [15:0] progAddr, a;
	iopbm_pmode_t progMode;
	logic progWrite, romBlocked, coreRun, periphRun;
	logic [1:0] lockBits;
	logic [7:0] lat [4];
	logic [3:0] mcode [6] = '{4'h3, 4'h0, 4'hb, 4'ha, 4'hf, 4'hc};
	iopbm_pmode_t mexp [6] = '{IOPBM_PM_VERIFY, IOPBM_PM_SIG, IOPBM_PM_CODE,
		IOPBM_PM_KEY, IOPBM_PM_LOCK1, IOPBM_PM_LOCK2};
	integer seed = 65;
	int miscompares = 0;
	int total_checks = 0;
	logic [15:0] writePulses = 16'h0000, wrAddr = 16'h0000;
	logic [7:0] wrData = 8'h00;
	assign allOe = {p3Oe, p2Oe, p1Oe, p0Oe};
	iopbm_ports dut_u (.*);
	iopbm_prog_model prog_u (.*);
	// The write strobe stands one cycle, so it is caught at every edge.
	always @(posedge ref_clk) begin
		if (progWrite === 1'b1) begin
			writePulses <= writePulses + 16'h0001;
			wrAddr <= progAddr;
			wrData <= progData;
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic cmpv(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic doReset;
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		tick(2);
	endtask
	task automatic wrLatch(input int p, input logic [7:0] v);
		@(posedge ref_clk);
		latchWr <= 4'h1 << p;
		latchData <= v;
		@(posedge ref_clk);
		latchWr <= 4'h0;
		tick(6);
	endtask
	// Pins settle through the synchronisers before anything is read.
	task automatic setPins(input logic [3:0] m, input logic [11:0] x,
		input logic [7:0] v);
		@(posedge ref_clk);
		drv2 <= {m[3:2], 2'b11, x[11:8]};
		drv3 <= {m[1:0], 6'h3f};
		drv1 <= x[7:0];
		drv0 <= v;
		tick(8);
	endtask
	task automatic pulse;
		@(posedge ref_clk);
		progPulse <= 1'b0;
		repeat (4) @(posedge ref_clk);
		progPulse <= 1'b1;
		tick(8);
	endtask
	function automatic logic [7:0] expRom(input logic [11:0] x);
		return x[7:0] ^ {x[11:8], x[11:8]} ^ 8'h5a;
	endfunction
	task automatic verify(input logic [11:0] x, input logic [7:0] key);
		setPins(4'h3, x, 8'hff);
		cmpv(progAddr, {4'h0, x});
		cmpv(p0In, {8'h00, ~(expRom(x) ^ key)});
	endtask
	task automatic pwr(input logic [2:0] r, input logic [1:0] e);
		@(posedge ref_clk);
		{wakeIrq, downReq, idleReq} <= r;
		@(posedge ref_clk);
		{wakeIrq, downReq, idleReq} <= 3'b000;
		tick(2);
		cmpv({coreRun, periphRun}, e);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#500000;
		miscompares++;
		tally_and_finish;
	end
	initial begin
		doReset;
		cmpv({p0Oe, p1Oe}, 16'h0000);
		cmpv({p2Oe, p3Oe}, 16'h0000);
		cmpv(p2Out, 16'h00ff);
		cmpv({p1Out, p3Out}, 16'hffff);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			d = (i < 2) ? {8{i[0]}} : 8'($random(seed));
			wrLatch(i % 4, d);
			lat[i % 4] = d;
			cmpv(allOe[8 * (i % 4) +: 8], {8'h00, ~d});
			cmpv(portRead[8 * (i % 4) +: 8], d);
		end
		$display("test latches done");
		for (int i = 0; i < 6; i++) begin
			a = 16'($random(seed));
			d = 8'($random(seed));
			@(posedge ref_clk);
			busCycle <= iopbm_bus_t'(1 + i % 3);
			busAddr <= a;
			busWrData <= d;
			busAddrPhase <= 1'b1;
			tick(2);
			cmpv({p0Oe, p0Out}, {8'hff, a[7:0]});
			cmpv(p2Out, (i % 3 == 2) ? lat[2] : a[15:8]);
			@(posedge ref_clk);
			busAddrPhase <= 1'b0;
			busWrite <= 1'b1;
			tick(2);
			cmpv({p0Oe, p0Out}, {8'hff, d});
			@(posedge ref_clk);
			busWrite <= 1'b0;
			tick(2);
			cmpv(p0Oe, 16'h0000);
		end
		@(posedge ref_clk);
		busCycle <= IOPBM_BUS_IDLE;
		$display("test bus done");
		doReset;
		@(posedge ref_clk);
		progEntry <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			setPins(mcode[i], 12'($random(seed)), 8'hff);
			cmpv(progMode, mexp[i]);
		end
		for (int i = 0; i < 4; i++) begin
			a = 16'($random(seed));
			verify(a[11:0], 8'hff);
		end
		k = 8'($random(seed));
		setPins(4'ha, {7'h00, a[4:0]}, k);
		pulse;
		verify({~a[11:5], a[4:0]}, k);
		verify({a[11:5], a[4:0] ^ 5'h01}, 8'hff);
		setPins(4'hb, a[11:0], k);
		pulse;
		cmpv(writePulses, 16'h0001);
		cmpv(wrAddr, {4'h0, a[11:0]});
		cmpv(wrData, {8'h00, k});
		setPins(4'hc, 12'h000, 8'hff);
		pulse;
		cmpv(lockBits, 16'h0002);
		setPins(4'ha, {7'h00, a[4:0]}, 8'h00);
		pulse;
		verify(a[11:0], k);
		setPins(4'hb, a[11:0], 8'h00);
		pulse;
		cmpv(writePulses, 16'h0001);
		@(posedge ref_clk);
		extFetch <= 1'b1;
		intRomRead <= 1'b1;
		tick(3);
		cmpv(romBlocked, 16'h0001);
		setPins(4'hf, 12'h000, 8'hff);
		pulse;
		cmpv(lockBits, 16'h0003);
		setPins(4'h3, a[11:0], 8'hff);
		cmpv(p0In, 16'h00ff);
		setPins(4'hf, 12'hfff, 8'hff);
		@(posedge ref_clk);
		progEntry <= 1'b0;
		extFetch <= 1'b0;
		intRomRead <= 1'b0;
		$display("test programming done");
		doReset;
		@(posedge ref_clk);
		clkEn <= 1'b0;
		wrLatch(1, 8'h00);
		@(posedge ref_clk);
		clkEn <= 1'b1;
		tick(4);
		cmpv(p1Oe, 16'h0000);
		pwr(3'b001, 2'b01);
		@(posedge ref_clk);
		extFetch <= 1'b1;
		tick(2);
		cmpv({p0Oe, p2Oe}, 16'h00ff);
		cmpv(p2Out, {8'h00, busAddr[15:8]});
		@(posedge ref_clk);
		extFetch <= 1'b0;
		pwr(3'b100, 2'b11);
		pwr(3'b010, 2'b00);
		wrLatch(1, 8'h00);
		cmpv(p1Oe, 16'h0000);
		doReset;
		cmpv({coreRun, periphRun}, 16'h0003);
		$display("test power done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
